// ==== rpc_pkg.sv ====
// Package for the reference percentage channel: modes, limits, defaults.
// Assumes percentages in hundredths of a percent, signed 16-bit.
package rpc_pkg;
  localparam int PW = 16;
  typedef logic signed [PW-1:0] rpc_pct_t;

  localparam rpc_pct_t PCT_ZERO     = 16'sh0000;
  localparam rpc_pct_t PCT_LIMIT    = 16'sh7530;   // 300.00 %
  localparam rpc_pct_t PCT_NLIMIT   = -16'sh7530;
  localparam rpc_pct_t PCT_SAT_MAX  = 16'sh7fff;
  localparam rpc_pct_t PCT_SAT_MIN  = -16'sh8000;
  localparam rpc_pct_t PRESET1_DEF  = 16'sh0000;
  localparam rpc_pct_t PRESET2_DEF  = 16'sh07d0;   // 20.00 %
  localparam rpc_pct_t PRESET3_DEF  = 16'sh1388;   // 50.00 %
  localparam rpc_pct_t PRESET4_DEF  = 16'sh2710;   // 100.00 %
  localparam rpc_pct_t MAX_REF_DEF  = 16'sh2710;

  // Gradient in %/ms (whole percent), hundredths per tick derived in core.
  localparam logic [15:0] GRAD_MAX     = 16'hea60;  // 60000 %/ms
  localparam logic [15:0] GRAD_DEF     = 16'h000a;  // 10 %/ms
  localparam int          CLK_HZ       = 125000000;
  localparam int          TICK_US      = 1000;      // limiter update period
  localparam int          TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;

  typedef enum logic [3:0]
  {
    SIGN_OFF  = 4'h1,
    SIGN_BOTH = 4'h2,
    SIGN_POS  = 4'h4,
    SIGN_INV  = 4'h8
  } rpc_sign_t;

  localparam logic [1:0] SIGN_MODE_DEF = 2'h1;
  localparam logic [1:0] POT_MODE_DEF  = 2'h0;

  typedef struct packed
  {
    logic [1:0] sign_mode;
    logic [1:0] pot_mode;
    rpc_pct_t   max_ref;
    rpc_pct_t   min_ref;
    logic [15:0] grad;
    logic [15:0] pot_ramp;
  } rpc_cfg_t;
endpackage : rpc_pkg

// ==== rpc_slew.sv ====
// Slew limiter stepping an output toward a target once per tick.
// Assumes step is a non-negative count of hundredths per tick.
`timescale 1ns/1ns
module rpc_slew
  import rpc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             tick,
  input  wire logic             bypass,
  input  wire logic [PW:0]      step,
  input  wire rpc_pkg::rpc_pct_t target,
  output rpc_pkg::rpc_pct_t     value
);
  logic signed [PW+1:0] diff;
  logic signed [PW+1:0] sstep;

  always_comb
  begin
    diff  = 18'(target) - 18'(value);
    sstep = 18'($signed({1'b0, step}));
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      value <= PCT_ZERO;
    else if (bypass)
      value <= target;
    else if (tick)
    begin
      if (diff > sstep)
        value <= PW'(18'(value) + sstep);
      else if (diff < -sstep)
        value <= PW'(18'(value) - sstep);
      else
        value <= target;
    end
  end
endmodule : rpc_slew

// ==== rpc_channel.sv ====
// Reference percentage channel: sources, sign mode, presets, slew, up/down.
// Assumes synchronous control inputs and external non-volatile storage.
`timescale 1ns/1ns
module rpc_channel
  import rpc_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire rpc_pkg::rpc_cfg_t cfg,
  input  wire logic             cfg_we,
  input  wire logic             preset_we,
  input  wire logic [3:0]       preset_idx,
  input  wire rpc_pkg::rpc_pct_t preset_wdata,
  input  wire logic [1:0]       src1_sel,
  input  wire logic [1:0]       src2_sel,
  input  wire rpc_pkg::rpc_pct_t analog_in,
  input  wire logic             fix_sel1_pin,
  input  wire logic             fix_sel1_int,
  input  wire logic             fix_sel1_use_int,
  input  wire logic             fix_sel2_pin,
  input  wire logic             fix_sel2_int,
  input  wire logic             fix_sel2_use_int,
  input  wire logic [1:0]       fix_sel_assigned,
  input  wire logic [1:0]       data_set,
  input  wire logic             pot_in_up,
  input  wire logic             pot_in_down,
  input  wire logic             pot_key_up,
  input  wire logic             pot_key_down,
  input  wire logic             drive_start,
  input  wire logic             torque_mode,
  input  wire logic             reverse_ccw,
  input  wire logic             reverse_key,
  input  wire rpc_pkg::rpc_pct_t nv_pot_value,
  input  wire logic             nv_pot_valid,
  output rpc_pkg::rpc_pct_t     ref_pct,
  output rpc_pkg::rpc_pct_t     pot_value,
  output logic                  nv_pot_store,
  output logic [1:0]            sign_mode,
  output logic [15:0]           grad
);
  import rpc_pkg::*;

  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_INPOT = 2'h1;
  localparam logic [1:0] SRC_KEYPOT = 2'h2;
  localparam logic [1:0] SRC_ANALOG = 2'h3;
  localparam logic [1:0] POT_LATCH_BIT = 2'h1;
  localparam logic [1:0] POT_TAKE_BIT = 2'h2;
  localparam int         NPRESET = 16;

  //////////////////////////////////////////////////////////////////////////
  // Configuration. Out-of-range gradient writes are clipped so the core never sees
  // an illegal gradient.
  logic [1:0]  pot_mode;
  rpc_pct_t    max_ref;
  rpc_pct_t    min_ref;
  logic [15:0] pot_ramp;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sign_mode <= SIGN_MODE_DEF;
      pot_mode  <= POT_MODE_DEF;
      max_ref   <= MAX_REF_DEF;
      min_ref   <= PCT_ZERO;
      grad      <= GRAD_DEF;
      pot_ramp  <= GRAD_DEF;
    end
    else if (cfg_we)
    begin
      sign_mode <= cfg.sign_mode;
      pot_mode  <= cfg.pot_mode;
      max_ref   <= cfg.max_ref;
      min_ref   <= cfg.min_ref;
      grad      <= (cfg.grad > GRAD_MAX) ? GRAD_MAX : cfg.grad;
      pot_ramp  <= cfg.pot_ramp;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Preset table: four per data set, sixteen in all.
  rpc_pct_t preset [NPRESET];

  genvar gi;
  generate
    for (gi = 0; gi < NPRESET; gi++)
    begin : g_preset
      always_ff @(posedge clk)
      begin
        if (reset)
          preset[gi] <= (gi % 4 == 0) ? PRESET1_DEF :
                        (gi % 4 == 1) ? PRESET2_DEF :
                        (gi % 4 == 2) ? PRESET3_DEF : PRESET4_DEF;
        else if (preset_we && preset_idx == 4'(gi))
        begin
          if (preset_wdata > PCT_LIMIT)
            preset[gi] <= PCT_LIMIT;
          else if (preset_wdata < PCT_NLIMIT)
            preset[gi] <= PCT_NLIMIT;
          else
            preset[gi] <= preset_wdata;
        end
      end
    end
  endgenerate

  logic       sel1;
  logic       sel2;
  logic [1:0] psel;
  rpc_pct_t   fixed_val;

  always_comb
  begin
    sel1 = fix_sel1_use_int ? fix_sel1_int : fix_sel1_pin;
    sel2 = fix_sel2_use_int ? fix_sel2_int : fix_sel2_pin;
    if (!fix_sel_assigned[0])
      sel1 = 1'b0;
    if (!fix_sel_assigned[1])
      sel2 = 1'b0;
    unique case ({sel1, sel2})
      2'b00: psel = 2'h0;
      2'b10: psel = 2'h1;
      2'b11: psel = 2'h2;
      2'b01: psel = 2'h3;
    endcase
    fixed_val = preset[{data_set, psel}];
  end

  //////////////////////////////////////////////////////////////////////////
  // Tick timing and step sizes. Gradient in %/ms becomes hundredths/tick.
  logic [$clog2(TICK+1)-1:0] tick_cnt;
  logic                      tick;
  logic [PW:0]               grad_step;
  logic [PW:0]               pot_step;
  logic [31:0]               gprod;
  logic [31:0]               pprod;

  always_ff @(posedge clk)
  begin
    if (reset || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  always_comb
  begin
    tick  = (tick_cnt == ($clog2(TICK+1))'(TICK - 1));
    gprod = 32'(grad) * 32'(TICK_US) / 32'd10;
    pprod = 32'(pot_ramp) * 32'(TICK_US) / 32'd10;
    if (pprod > gprod)
      pprod = gprod;
    grad_step = (gprod > 32'h0000ffff) ? 17'h0ffff : 17'(gprod);
    pot_step  = (pprod > 32'h0000ffff) ? 17'h0ffff : 17'(pprod);
    if (pot_step == 17'h00000)
      pot_step = 17'h00001;
  end

  //////////////////////////////////////////////////////////////////////////
  // Up/down setpoint: both input and keypad act together when chosen.
  logic pot_active;
  logic pot_active_q;
  logic up;
  logic down;
  logic start_q;
  logic start_rise;
  rpc_pct_t other_val;
  logic signed [PW+1:0] pot_next;

  always_comb
  begin
    pot_active = (src1_sel == SRC_INPOT) || (src1_sel == SRC_KEYPOT) ||
                 (src2_sel == SRC_INPOT) || (src2_sel == SRC_KEYPOT);
    up   = ((src1_sel == SRC_INPOT || src2_sel == SRC_INPOT) && pot_in_up) ||
           ((src1_sel == SRC_KEYPOT || src2_sel == SRC_KEYPOT) &&
            pot_key_up);
    down = ((src1_sel == SRC_INPOT || src2_sel == SRC_INPOT) &&
            pot_in_down) ||
           ((src1_sel == SRC_KEYPOT || src2_sel == SRC_KEYPOT) &&
            pot_key_down);
    start_rise = drive_start && !start_q;
    other_val  = (src1_sel == SRC_FIXED || src2_sel == SRC_FIXED) ?
                 fixed_val : analog_in;
    pot_next = 18'(pot_value);
    if (up && !down)
      pot_next = 18'(pot_value) + 18'($signed({1'b0, pot_step}));
    else if (down && !up)
      pot_next = 18'(pot_value) - 18'($signed({1'b0, pot_step}));
    if (pot_next > 18'(max_ref))
      pot_next = 18'(max_ref);
    if (pot_next < -18'(max_ref))
      pot_next = -18'(max_ref);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_q      <= 1'b0;
      pot_active_q <= 1'b0;
    end
    else
    begin
      start_q      <= drive_start;
      pot_active_q <= pot_active;
    end
  end

  // Retention is only as good as the external store; a missing valid
  // leaves the setpoint at its current value.
  always_ff @(posedge clk)
  begin
    if (reset)
      pot_value <= PCT_ZERO;
    else if (pot_active && !pot_active_q && pot_mode[1])
      pot_value <= other_val;
    else if (start_rise && !pot_mode[0])
      pot_value <= min_ref;
    else if (start_rise && nv_pot_valid && !pot_active_q)
      pot_value <= nv_pot_value;
    else if (tick && pot_active)
      pot_value <= PW'(pot_next);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      nv_pot_store <= 1'b0;
    else
      nv_pot_store <= pot_mode[0] && tick && pot_active &&
                      (PW'(pot_next) != pot_value);
  end

  //////////////////////////////////////////////////////////////////////////
  // Source sum, sign mode and reversal.
  rpc_pct_t src1_val;
  rpc_pct_t src2_val;
  logic signed [PW+1:0] sum;
  logic signed [PW+1:0] shaped;
  rpc_pct_t target;
  logic     reverse;

  function automatic rpc_pct_t rpc_src(input logic [1:0] sel,
                                       input rpc_pct_t fv,
                                       input rpc_pct_t pv,
                                       input rpc_pct_t av);
    rpc_src = (sel == SRC_FIXED) ? fv :
              (sel == SRC_ANALOG) ? av : pv;
  endfunction : rpc_src

  always_comb
  begin
    src1_val = rpc_src(src1_sel, fixed_val, pot_value, analog_in);
    src2_val = (src2_sel == src1_sel && src1_sel != SRC_ANALOG &&
                src1_sel != SRC_FIXED) ? PCT_ZERO :
               rpc_src(src2_sel, fixed_val, pot_value, analog_in);
    sum      = 18'(src1_val) + 18'(src2_val);
    reverse  = torque_mode && (reverse_ccw || reverse_key);
    unique case (sign_mode)
      2'h0: shaped = '0;
      2'h1: shaped = sum;
      2'h2: shaped = (sum < 0) ? '0 :
                     (sum > 18'(max_ref)) ? 18'(max_ref) : sum;
      2'h3: shaped = -sum;
    endcase
    if (reverse)
      shaped = -shaped;
    if (shaped > 18'(PCT_SAT_MAX))
      target = PCT_SAT_MAX;
    else if (shaped < 18'(PCT_SAT_MIN))
      target = PCT_SAT_MIN;
    else
      target = PW'(shaped);
  end

  //////////////////////////////////////////////////////////////////////////
  // Output slew limiter.
  rpc_pct_t slewed;

  rpc_slew u_slew
  (
    .clk    (clk),
    .reset  (reset),
    .tick   (tick),
    .bypass (grad == 16'h0000),
    .step   (grad_step),
    .target (target),
    .value  (slewed)
  );

  always_comb
  begin
    ref_pct = (sign_mode == 2'h0) ? PCT_ZERO : slewed;
  end
endmodule : rpc_channel

// ==== rpc_ctl_model.sv ====
// Model of the select lines and keypad keys that feed the channel.
// Assumes the bench changes sel, use_int and keys at the falling edge.
`timescale 1ns/1ns
module rpc_ctl_model
(
  input  wire logic [1:0] sel,
  input  wire logic       use_int,
  input  wire logic [1:0] keys,
  output logic            sel1_pin,
  output logic            sel1_int,
  output logic            sel2_pin,
  output logic            sel2_int,
  output logic            key_up,
  output logic            key_down
);
  // The unused source shows the inverse, so a wrong pick cannot pass.
  assign sel1_pin = use_int ? ~sel[0] : sel[0];
  assign sel1_int = use_int ? sel[0] : ~sel[0];
  assign sel2_pin = use_int ? ~sel[1] : sel[1];
  assign sel2_int = use_int ? sel[1] : ~sel[1];
  assign key_up   = keys[1];
  assign key_down = keys[0];
endmodule : rpc_ctl_model

// ==== rpc_channel_properties.sv ====
// Checker of the percentage channel outputs.
// Assumes it is bound into rpc_channel and sees only its ports.
`timescale 1ns/1ns
module rpc_chk
  import rpc_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire rpc_pkg::rpc_cfg_t cfg,
  input wire logic              cfg_we,
  input wire logic              drive_start,
  input wire logic              torque_mode,
  input wire rpc_pkg::rpc_pct_t ref_pct,
  input wire rpc_pkg::rpc_pct_t pot_value,
  input wire logic              nv_pot_store,
  input wire logic [1:0]        sign_mode,
  input wire logic [15:0]       grad
);
  rpc_pct_t   max_q;
  rpc_pct_t   min_q;
  logic [1:0] pm_q;
  int         lim;
  assign lim = int'(grad) * TICK_US / 10;
  // Shadow of the written limits, since the checker cannot see inside.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      max_q <= MAX_REF_DEF;
      min_q <= PCT_ZERO;
      pm_q  <= POT_MODE_DEF;
    end
    else if (cfg_we)
    begin
      max_q <= cfg.max_ref;
      min_q <= cfg.min_ref;
      pm_q  <= cfg.pot_mode;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  property p_rst;
    $fell(reset) |-> ref_pct == PCT_ZERO && pot_value == PCT_ZERO &&
      !nv_pot_store && sign_mode == SIGN_MODE_DEF && grad == GRAD_DEF;
  endproperty
  a_rst: assert property (p_rst) else $error("Bad reset value.");
  property p_off;
    sign_mode == 2'h0 |-> ref_pct == PCT_ZERO;
  endproperty
  a_off: assert property (p_off) else $error("Off not zero.");
  property p_grad;
    cfg_we |=> grad == (($past(cfg.grad) > GRAD_MAX) ? GRAD_MAX :
      $past(cfg.grad));
  endproperty
  a_grad: assert property (p_grad) else $error("Bad gradient.");
  property p_mode;
    cfg_we |=> sign_mode == $past(cfg.sign_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("Bad sign mode.");
  property p_pos;
    sign_mode == 2'h2 && $past(sign_mode) == 2'h2 && grad == 16'h0000 &&
      $past(grad) == 16'h0000 && !torque_mode && !$past(torque_mode) &&
      $stable(max_q) |-> ref_pct >= 0 && ref_pct <= max_q;
  endproperty
  a_pos: assert property (p_pos) else $error("Clamp broken.");
  property p_step;
    grad != 16'h0000 && $stable(grad) && $stable(sign_mode) &&
      sign_mode != 2'h0 && $stable(torque_mode) |->
      int'(ref_pct) - int'($past(ref_pct)) <= lim &&
      int'($past(ref_pct)) - int'(ref_pct) <= lim;
  endproperty
  a_step: assert property (p_step) else $error("Step too big.");
  property p_store;
    nv_pot_store |=> !nv_pot_store;
  endproperty
  a_store: assert property (p_store) else $error("Store held.");
  sequence s_start;
    $rose(drive_start) && pm_q == 2'h0;
  endsequence
  sequence s_min;
    ##[1:3] pot_value == min_q;
  endsequence
  property p_start;
    s_start |-> s_min;
  endproperty
  a_start: assert property (p_start) else $error("No restart.");
endmodule : rpc_chk
bind rpc_channel rpc_chk u_rpc_chk (.clk, .reset, .cfg, .cfg_we,
  .drive_start, .torque_mode, .ref_pct, .pot_value, .nv_pot_store,
  .sign_mode, .grad);

// ==== rpc_channel_tb_top.sv ====
// Bench of the percentage channel: presets, sign modes, slew, up/down.
// Assumes the channel, its checker and the control model compiled first.
`timescale 1ns/1ns
module rpc_channel_tb_top;
  import rpc_pkg::*;
  localparam int TK = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  rpc_cfg_t    cfg;
  logic        cfg_we = 1'b0;
  logic        preset_we = 1'b0;
  logic [3:0]  preset_idx = 4'h0;
  rpc_pct_t    preset_wdata = 16'sh0000;
  logic [1:0]  src1_sel = 2'h0;
  logic [1:0]  src2_sel = 2'h3;
  rpc_pct_t    analog_in = 16'sh0100;
  logic [1:0]  sel = 2'h0;
  logic        use_int = 1'b0;
  logic [1:0]  keys = 2'h0;
  logic        pin_up = 1'b0;
  logic        nv_ok = 1'b0;
  rpc_pct_t    nv_val = 16'sh0000;
  int          n_store = 0;
  logic [1:0]  asg = 2'h3;
  logic [1:0]  data_set = 2'h0;
  logic        drive_start = 1'b0;
  logic        torque_mode = 1'b0;
  logic        reverse_ccw = 1'b0;
  logic        reverse_key = 1'b0;
  logic        s1p, s1i, s2p, s2i, kup, kdn;
  rpc_pct_t    ref_pct;
  rpc_pct_t    pot_value;
  logic        nv_pot_store;
  logic [1:0]  sign_mode;
  logic [15:0] grad;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [1:0]  sv [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  rpc_pct_t    pv [4] = '{PRESET1_DEF, PRESET2_DEF, PRESET3_DEF,
                          PRESET4_DEF};
  logic [1:0]  mv [4] = '{2'h3, 2'h0, 2'h2, 2'h2};
  rpc_pct_t    av [4] = '{16'shfc00, 16'shfc00, 16'shf000, 16'sh3000};
  rpc_pct_t    ev [4] = '{16'shfc30, 16'sh0000, 16'sh0000, 16'sh2710};
  rpc_channel #(.TICK(TK)) DUT (.clk, .reset, .cfg, .cfg_we, .preset_we,
    .preset_idx, .preset_wdata, .src1_sel, .src2_sel, .analog_in,
    .fix_sel1_pin(s1p), .fix_sel1_int(s1i), .fix_sel1_use_int(use_int),
    .fix_sel2_pin(s2p), .fix_sel2_int(s2i), .fix_sel2_use_int(use_int),
    .fix_sel_assigned(asg), .data_set, .pot_in_up(pin_up),
    .pot_in_down(1'b0), .pot_key_up(kup), .pot_key_down(kdn),
    .drive_start, .torque_mode, .reverse_ccw, .reverse_key,
    .nv_pot_value(nv_val), .nv_pot_valid(nv_ok), .ref_pct, .pot_value,
    .nv_pot_store, .sign_mode, .grad);
  rpc_ctl_model u_ctl (.sel, .use_int, .keys, .sel1_pin(s1p),
    .sel1_int(s1i), .sel2_pin(s2p), .sel2_int(s2i), .key_up(kup),
    .key_down(kdn));
  ////////////////////////////////////////
  always #4 clk = ~clk;
  // The whole run needs under a thousand cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      end_sim();
    end
  end
  // Store pulses are one cycle wide, so they are counted as they come.
  always @(posedge clk)
  begin
    if (nv_pot_store === 1'b1)
      n_store++;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic chk(input rpc_pct_t got, input rpc_pct_t exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic set_cfg(input logic [1:0] sm, input logic [15:0] g);
    cfg.sign_mode = sm;
    cfg.grad = g;
    cfg_we = 1'b1;
    wt(1);
    cfg_we = 1'b0;
    wt(2);
  endtask : set_cfg
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////
  initial
  begin
    cfg = {2'h1, 2'h0, 16'sh2710, 16'sh0200, 16'h0000, 16'hffff};
    wt(3);
    reset = 1'b0;
    wt(1);
    chk(sign_mode, SIGN_MODE_DEF);
    chk(grad, GRAD_DEF);
    set_cfg(2'h1, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      sel = sv[i];
      use_int = i[0];
      wt(3);
      chk(ref_pct, pv[i] + 16'sh0100);
    end
    asg = 2'h1;
    sel = 2'h3;
    wt(3);
    chk(ref_pct, PRESET2_DEF + 16'sh0100);
    asg = 2'h3;
    // Two preset writes back to back, both out of range.
    preset_we = 1'b1;
    preset_idx = 4'h5;
    preset_wdata = 16'sh7fff;
    wt(1);
    preset_idx = 4'h4;
    preset_wdata = 16'sh8000;
    wt(1);
    preset_we = 1'b0;
    data_set = 2'h1;
    sel = 2'h1;
    wt(3);
    chk(ref_pct, 16'sh7630);
    sel = 2'h0;
    wt(3);
    chk(ref_pct, 16'sh8bd0);
    data_set = 2'h0;
    sel = 2'h1;
    for (int i = 0; i < 4; i++)
    begin
      analog_in = av[i];
      set_cfg(mv[i], 16'h0000);
      wt(1);
      chk(ref_pct, ev[i]);
    end
    set_cfg(2'h1, 16'h0000);
    analog_in = 16'sh0000;
    reverse_ccw = 1'b1;
    wt(3);
    chk(ref_pct, PRESET2_DEF);
    torque_mode = 1'b1;
    wt(3);
    chk(ref_pct, -PRESET2_DEF);
    reverse_ccw = 1'b0;
    reverse_key = 1'b1;
    wt(3);
    chk(ref_pct, -PRESET2_DEF);
    reverse_key = 1'b0;
    torque_mode = 1'b0;
    set_cfg(2'h1, 16'hffff);
    chk(grad, GRAD_MAX);
    set_cfg(2'h1, 16'h0001);
    analog_in = 16'sh03e8;
    wt(3 * TK);
    chk(ref_pct >= 16'sh0834 && ref_pct <= 16'sh0960, 16'sh0001);
    wt(10 * TK);
    chk(ref_pct, 16'sh0bb8);
    set_cfg(2'h1, 16'h0000);
    analog_in = 16'sh0000;
    wt(2);
    chk(ref_pct, PRESET2_DEF);
    src1_sel = 2'h2;
    set_cfg(2'h1, 16'h0001);
    drive_start = 1'b1;
    wt(4);
    chk(pot_value, 16'sh0200);
    keys = 2'h2;
    wt(20 * TK);
    chk(pot_value > 16'sh0200 && pot_value <= 16'sh0a40, 16'sh0001);
    keys = 2'h0;
    drive_start = 1'b0;
    wt(2);
    drive_start = 1'b1;
    wt(4);
    chk(pot_value, 16'sh0200);
    src2_sel = 2'h1;
    pin_up = 1'b1;
    wt(3 * TK);
    pin_up = 1'b0;
    chk(pot_value > 16'sh0200 && pot_value <= 16'sh0390, 16'sh0001);
    cfg.pot_mode = 2'h2;
    set_cfg(2'h1, 16'h0001);
    src1_sel = 2'h0;
    src2_sel = 2'h3;
    wt(2);
    src2_sel = 2'h1;
    wt(2);
    chk(pot_value, PRESET2_DEF);
    cfg.pot_mode = 2'h1;
    set_cfg(2'h1, 16'h0001);
    nv_val = 16'sh0456;
    nv_ok = 1'b1;
    src2_sel = 2'h3;
    drive_start = 1'b0;
    wt(2);
    drive_start = 1'b1;
    wt(2);
    chk(pot_value, 16'sh0456);
    src2_sel = 2'h1;
    pin_up = 1'b1;
    wt(2 * TK);
    pin_up = 1'b0;
    chk(16'(n_store != 0), 16'sh0001);
    cfg.pot_mode = 2'h3;
    set_cfg(2'h1, 16'h0001);
    src2_sel = 2'h3;
    wt(2);
    src2_sel = 2'h1;
    wt(2);
    chk(pot_value, PRESET2_DEF);
    set_cfg(2'h1, 16'h0000);
    src2_sel = 2'h3;
    data_set = 2'h1;
    analog_in = 16'sh7fff;
    wt(3);
    chk(ref_pct, PCT_SAT_MAX);
    end_sim();
  end
endmodule : rpc_channel_tb_top
